//--- core/mts_core.sv
// trigger sequencer core: trigger counting, delays, reading hold, done handshake
// all inputs synchronous to CLK_I except EXT_TRIG_N_I, which is synchronised here
// What this block does
// - default: one trigger, then back to idle
// - trigger count 1..50000 or unlimited
// - local mode ignores count; remote restores it
// - count forced to 1 on resets, configure
// - programmable delay 0..3600 s, auto default
// - delay returns to auto on resets, configure
// - fixed delay same for every function, range
// - delay inserted before every reading of burst
// - dc auto delay 1.5 or 1.0 ms
// - resistance auto delay depends on range
// - ac remote/single delays 7 s, 1 s, 600 ms
// - ac front-panel auto delays 1.5 s, 200, 100 ms
// - frequency/period delay 1 s or zero
// - hold updates after three readings in band
// - band choices 0.01, 0.10, 1.00, 10.00 percent
// - band returns to 0.10 percent on resets
// - stable reading latched, beep if enabled
// - hold suspended in remote, resumes in local
// - one low pulse per finished measurement
// - remote honours external input only if selected
// - each trigger starts burst of sample count
// - one external trigger during reading is stored
// - external triggers ignored during 20 ms set-up
// - device clear aborts to idle, keeps settings
`timescale 1ns/1ps
module mts_core #(
   parameter int unsigned US_CYC = mts_pkg::US_CYC_DEF,
   parameter int unsigned SETUP_US = mts_pkg::SETUP_US
) (
   input wire logic CLK_I, // system clock
   input wire logic SRST_I, // power-up reset, sync, high
   input wire logic IFC_RESET_I, // interface reset pulse
   input wire logic CONFIG_CMD_I, // configure or query_cmd_a executes
   input wire logic DEV_CLEAR_I, // device clear pulse
   input wire logic REMOTE_I, // 1 remote, 0 local
   input wire logic [1:0] TRIG_SRC_I, // remote source: bus, immediate, external
   input wire logic AUTO_TRIG_I, // local: auto trigger on
   input wire logic ARM_I, // enter wait-for-trigger (remote)
   input wire logic BUS_TRIG_I, // software trigger pulse
   input wire logic SINGLE_I, // front-panel single key pulse
   input wire logic EXT_TRIG_N_I, // external trigger pin, low true
   input wire logic SET_TRIG_COUNT_I, // load trigger count
   input wire logic [15:0] TRIG_COUNT_I, // trigger count value
   input wire logic UNLIMITED_TRIGGERS_I, // with load: unlimited
   input wire logic SET_SAMPLE_COUNT_I, // load sample count
   input wire logic [15:0] SAMPLE_COUNT_I, // sample count value
   input wire logic SET_DELAY_I, // load fixed delay
   input wire logic [31:0] DELAY_US_I, // fixed delay, microseconds
   input wire logic SET_AUTO_DELAY_I, // select automatic delay
   input wire logic [2:0] FUNC_I, // measurement function code
   input wire logic [2:0] RANGE_I, // resistance range code
   input wire logic INTEGRATION_LINE_CYCLES_GE1_I, // integration_line_cycles >= 1
   input wire logic [1:0] AC_FILTER_I, // ac filter code
   input wire logic MEAS_DONE_I, // analog reading finished pulse
   input wire logic [31:0] READING_I, // reading magnitude with done
   input wire logic HOLD_EN_I, // reading hold enabled
   input wire logic SET_BAND_I, // load hold band
   input wire logic [1:0] BAND_SEL_I, // 0.01,0.10,1.00,10.00 percent
   input wire logic BEEP_EN_I, // beeper enabled
   output logic MEAS_START_O, // start one reading, pulse
   output logic MEASUREMENT_DONE_OUT_N_O, // complete, low pulse
   output logic WAIT_TRIG_O, // in wait-for-trigger
   output logic BUSY_O, // delay or reading in progress
   output logic [31:0] HELD_VALUE_O, // held reading
   output logic HELD_VALID_O, // held reading present
   output logic BEEP_O // beep request pulse
);
   if (US_CYC < 1 || US_CYC > 65535 || SETUP_US < 1)
      $error("mts_core: US_CYC or SETUP_US out of range");

   mts_pkg::mts_state_t s_q;
   mts_pkg::mts_state_t s_d;
   logic ext_fall;
   logic ext_ok;
   logic fire;
   logic tick;
   logic in_band;
   logic [31:0] diff;
   logic [45:0] lhs;
   logic [45:0] rhs;
   logic [45:0] bp;
   logic [15:0] tc_new;
   logic [15:0] sc_new;

   assign ext_fall = s_q.ext_sync[2] & ~s_q.ext_sync[1];
   // external input is honoured in remote only with the external source
   assign ext_ok = REMOTE_I ? (TRIG_SRC_I == mts_pkg::SRC_EXT) : ~AUTO_TRIG_I;
   assign tick = (s_q.pre == 16'(US_CYC - 1));
   assign diff = (s_q.ref_val > READING_I) ? s_q.ref_val - READING_I : READING_I - s_q.ref_val;
   assign lhs = 46'(diff) * mts_pkg::BAND_SCALE;
   assign rhs = 46'(s_q.ref_val) * bp;
   assign in_band = (lhs <= rhs);
   assign tc_new = (TRIG_COUNT_I == 16'h0) ? 16'h1 :
      (TRIG_COUNT_I > mts_pkg::MAX_COUNT) ? mts_pkg::MAX_COUNT : TRIG_COUNT_I;
   assign sc_new = (SAMPLE_COUNT_I == 16'h0) ? 16'h1 :
      (SAMPLE_COUNT_I > mts_pkg::MAX_COUNT) ? mts_pkg::MAX_COUNT : SAMPLE_COUNT_I;

   always_comb
   begin
      case (s_q.band)
         2'h0: bp = 46'd1;
         2'h1: bp = 46'd10;
         2'h2: bp = 46'd100;
         default: bp = 46'd1000;
      endcase
      if (REMOTE_I)
      begin
         case (TRIG_SRC_I)
            mts_pkg::SRC_IMM: fire = 1'b1;
            mts_pkg::SRC_BUS: fire = BUS_TRIG_I;
            mts_pkg::SRC_EXT: fire = ext_fall | s_q.pending;
            default: fire = 1'b0;
         endcase
      end
      else
         fire = AUTO_TRIG_I | SINGLE_I | ext_fall | s_q.pending;
   end

   always_comb
   begin
      s_d = s_q;
      s_d.ext_sync = {s_q.ext_sync[1:0], EXT_TRIG_N_I};
      s_d.start = 1'b0;
      s_d.beep = 1'b0;
      s_d.done_n = 1'b1;
      s_d.pre = tick ? 16'h0 : s_q.pre + 16'h1;
      if (tick && s_q.cnt != 32'h0)
         s_d.cnt = s_q.cnt - 32'h1;
      // settings
      if (SET_TRIG_COUNT_I)
      begin
         s_d.trig_cnt = tc_new;
         s_d.unlimited = UNLIMITED_TRIGGERS_I;
      end
      if (SET_SAMPLE_COUNT_I)
         s_d.samp_cnt = sc_new;
      if (SET_DELAY_I)
      begin
         s_d.auto_dly = 1'b0;
         s_d.dly_us = (DELAY_US_I > mts_pkg::MAX_DELAY_US) ? mts_pkg::MAX_DELAY_US : DELAY_US_I;
      end
      if (SET_AUTO_DELAY_I)
         s_d.auto_dly = 1'b1;
      if (SET_BAND_I)
         s_d.band = BAND_SEL_I;
      // stored external trigger; a device clear or interface reset below beats a new edge
      if ((s_q.st == mts_pkg::ST_DELAY || s_q.st == mts_pkg::ST_MEAS) && ext_fall && ext_ok)
         s_d.pending = 1'b1;
      case (s_q.st)
         mts_pkg::ST_IDLE:
         begin
            if (!REMOTE_I)
               s_d.st = mts_pkg::ST_WAIT;
            else if (ARM_I)
            begin
               s_d.st = mts_pkg::ST_SETUP;
               s_d.cnt = 32'(SETUP_US);
               s_d.pre = 16'h0;
               s_d.trig_left = s_q.trig_cnt;
            end
         end
         mts_pkg::ST_SETUP:
         begin
            s_d.pending = 1'b0;
            if (s_q.cnt == 32'h0)
               s_d.st = mts_pkg::ST_WAIT;
         end
         mts_pkg::ST_WAIT:
         begin
            if (fire)
            begin
               s_d.pending = 1'b0;
               s_d.samp_left = s_q.samp_cnt;
               s_d.st = mts_pkg::ST_DELAY;
               s_d.pre = 16'h0;
               s_d.cnt = s_q.auto_dly ? mts_pkg::auto_delay_us(FUNC_I, RANGE_I, INTEGRATION_LINE_CYCLES_GE1_I,
                  AC_FILTER_I, ~REMOTE_I & AUTO_TRIG_I) : s_q.dly_us;
            end
         end
         mts_pkg::ST_DELAY:
         begin
            if (s_q.cnt == 32'h0)
            begin
               s_d.st = mts_pkg::ST_MEAS;
               s_d.start = 1'b1;
            end
         end
         mts_pkg::ST_MEAS:
         begin
            if (MEAS_DONE_I)
            begin
               s_d.done_n = 1'b0;
               if (HOLD_EN_I && !REMOTE_I)
               begin
                  if (in_band && s_q.stable == 2'h2)
                  begin
                     s_d.held = READING_I;
                     s_d.held_valid = 1'b1;
                     s_d.beep = BEEP_EN_I;
                     s_d.stable = 2'h0;
                  end
                  else if (in_band && s_q.stable != 2'h0)
                     s_d.stable = s_q.stable + 2'h1;
                  else
                  begin
                     s_d.ref_val = READING_I;
                     s_d.stable = 2'h1;
                  end
               end
               if (s_q.samp_left > 16'h1)
               begin
                  s_d.samp_left = s_q.samp_left - 16'h1;
                  s_d.st = mts_pkg::ST_DELAY;
                  s_d.pre = 16'h0;
                  s_d.cnt = s_q.auto_dly ? mts_pkg::auto_delay_us(FUNC_I, RANGE_I, INTEGRATION_LINE_CYCLES_GE1_I,
                     AC_FILTER_I, ~REMOTE_I & AUTO_TRIG_I) : s_q.dly_us;
               end
               else if (!REMOTE_I || s_q.unlimited)
                  s_d.st = mts_pkg::ST_WAIT;
               else if (s_q.trig_left <= 16'h1)
                  s_d.st = mts_pkg::ST_IDLE;
               else
               begin
                  s_d.trig_left = s_q.trig_left - 16'h1;
                  s_d.st = mts_pkg::ST_WAIT;
               end
            end
         end
         default: s_d.st = mts_pkg::ST_IDLE;
      endcase
      if (DEV_CLEAR_I)
      begin
         s_d.st = mts_pkg::ST_IDLE;
         s_d.pending = 1'b0;
         s_d.start = 1'b0;
      end
      if (CONFIG_CMD_I || IFC_RESET_I)
      begin
         s_d.trig_cnt = mts_pkg::COUNT_RST;
         s_d.unlimited = 1'b0;
         s_d.samp_cnt = mts_pkg::COUNT_RST;
         s_d.auto_dly = 1'b1;
      end
      if (IFC_RESET_I)
      begin
         s_d.band = mts_pkg::BAND_RST;
         s_d.st = mts_pkg::ST_IDLE;
         s_d.pending = 1'b0;
         s_d.start = 1'b0;
      end
      s_d.waiting = (s_d.st == mts_pkg::ST_WAIT);
      s_d.busy = (s_d.st == mts_pkg::ST_DELAY) || (s_d.st == mts_pkg::ST_MEAS);
   end

   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         s_q <= '0;
         s_q.st <= mts_pkg::ST_IDLE;
         s_q.ext_sync <= 3'h7;
         s_q.trig_cnt <= mts_pkg::COUNT_RST;
         s_q.samp_cnt <= mts_pkg::COUNT_RST;
         s_q.auto_dly <= 1'b1;
         s_q.band <= mts_pkg::BAND_RST;
         s_q.done_n <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   assign MEAS_START_O = s_q.start;
   assign MEASUREMENT_DONE_OUT_N_O = s_q.done_n;
   assign WAIT_TRIG_O = s_q.waiting;
   assign BUSY_O = s_q.busy;
   assign HELD_VALUE_O = s_q.held;
   assign HELD_VALID_O = s_q.held_valid;
   assign BEEP_O = s_q.beep;

   // helpers read only by the checks below
   logic in_meas;
   logic in_idle;
   logic in_setup;
   assign in_meas = (s_q.st == mts_pkg::ST_MEAS);
   assign in_idle = (s_q.st == mts_pkg::ST_IDLE);
   assign in_setup = (s_q.st == mts_pkg::ST_SETUP);

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);

   AST_DONE_ONE_CYCLE: assert property ($fell(MEASUREMENT_DONE_OUT_N_O) |=> MEASUREMENT_DONE_OUT_N_O)
      else $error("done pulse longer than one cycle");
   AST_DONE_CAUSE: assert property (!MEASUREMENT_DONE_OUT_N_O |-> $past(in_meas) && $past(MEAS_DONE_I))
      else $error("done pulse without finished reading");
   AST_IDLE_HIGH: assert property (in_idle && $past(in_idle) |-> MEASUREMENT_DONE_OUT_N_O)
      else $error("done low while idle");
   AST_SETUP_DISCARD: assert property (in_setup && !DEV_CLEAR_I |=> !s_q.pending)
      else $error("trigger stored during set-up");
   AST_STORE_EXT: assert property (in_meas && ext_fall && ext_ok && !DEV_CLEAR_I && !IFC_RESET_I
      |=> s_q.pending)
      else $error("external trigger during reading lost");
   AST_CFG_DEFAULTS: assert property (CONFIG_CMD_I |=> s_q.trig_cnt == 16'h1 && s_q.auto_dly
      && s_q.samp_cnt == 16'h1)
      else $error("configure did not restore defaults");
   AST_CLEAR_KEEPS: assert property (DEV_CLEAR_I && !CONFIG_CMD_I && !IFC_RESET_I
      && !SET_TRIG_COUNT_I && !SET_DELAY_I |=> in_idle && $stable(s_q.trig_cnt)
      && $stable(s_q.dly_us))
      else $error("device clear misbehaved");
   AST_DELAY_EACH: assert property (in_meas && MEAS_DONE_I && s_q.samp_left > 16'h1
      && !DEV_CLEAR_I && !IFC_RESET_I |=> s_q.st == mts_pkg::ST_DELAY)
      else $error("no delay before next sample");
   AST_ONE_TRIGGER: assert property (in_meas && MEAS_DONE_I && REMOTE_I && !s_q.unlimited
      && s_q.samp_left <= 16'h1 && s_q.trig_left <= 16'h1 |=> in_idle)
      else $error("did not return to idle");
   AST_HOLD_REMOTE: assert property (REMOTE_I |=> !BEEP_O)
      else $error("hold active in remote");
   AST_START_AFTER_DELAY: assert property (MEAS_START_O |-> $past(s_q.cnt) == 32'h0)
      else $error("reading started before delay expired");
   AST_BAND_RESET: assert property (IFC_RESET_I |=> s_q.band == mts_pkg::BAND_RST)
      else $error("band not restored");

   COV_BURST: cover property (MEAS_START_O ##[1:1000] MEAS_START_O);
   COV_PENDING: cover property (s_q.pending ##1 s_q.st == mts_pkg::ST_DELAY);
   COV_HOLD: cover property (BEEP_O);
   COV_IDLE_RETURN: cover property (in_meas ##1 in_idle);
endmodule // mts_core

//--- core/mts_pkg.sv
// constants, types and delay lookup for the measurement trigger sequencer
// assumes one 125 MHz system clock; delays are timed in microsecond ticks
package mts_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned US_PER_S = 1_000_000;
   localparam int unsigned US_CYC_DEF = CLK_HZ / US_PER_S;
   localparam int unsigned SETUP_US = 20_000;
   localparam longint unsigned MAX_DELAY_S = 3600;
   localparam logic [31:0] MAX_DELAY_US = 32'(MAX_DELAY_S * US_PER_S);
   localparam logic [15:0] MAX_COUNT = 16'd50000;
   localparam logic [15:0] COUNT_RST = 16'h0001;
   localparam logic [1:0] BAND_RST = 2'h1;
   localparam logic [45:0] BAND_SCALE = 46'd10000;
   // auto delays, microseconds
   localparam logic [31:0] D1MS0 = 32'd1000;
   localparam logic [31:0] D1MS5 = 32'd1500;
   localparam logic [31:0] D10MS = 32'd10000;
   localparam logic [31:0] D15MS = 32'd15000;
   localparam logic [31:0] D100MS = 32'd100000;
   localparam logic [31:0] D200MS = 32'd200000;
   localparam logic [31:0] D600MS = 32'd600000;
   localparam logic [31:0] D1S0 = 32'd1000000;
   localparam logic [31:0] D1S5 = 32'd1500000;
   localparam logic [31:0] D7S0 = 32'd7000000;
   // function codes
   localparam logic [2:0] FN_DCV = 3'h0;
   localparam logic [2:0] FN_DCI = 3'h1;
   localparam logic [2:0] FN_OHM2 = 3'h2;
   localparam logic [2:0] FN_OHM4 = 3'h3;
   localparam logic [2:0] FN_ACV = 3'h4;
   localparam logic [2:0] FN_ACI = 3'h5;
   localparam logic [2:0] FN_FREQ = 3'h6;
   localparam logic [2:0] FN_PER = 3'h7;
   // resistance range codes: 0 = 100 ohm ... 6 = 100 megohm
   localparam logic [2:0] RNG_1M = 3'h4;
   // ac filter codes
   localparam logic [1:0] FLT_SLOW = 2'h0;
   localparam logic [1:0] FLT_MED = 2'h1;
   // remote trigger sources
   localparam logic [1:0] SRC_BUS = 2'h0;
   localparam logic [1:0] SRC_IMM = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h2;

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WAIT, ST_DELAY, ST_MEAS} mts_st_t;

   typedef struct packed {
      mts_st_t st;
      logic [2:0] ext_sync;
      logic pending;
      logic [15:0] pre;
      logic [31:0] cnt;
      logic [15:0] trig_cnt;
      logic unlimited;
      logic [15:0] samp_cnt;
      logic [15:0] trig_left;
      logic [15:0] samp_left;
      logic auto_dly;
      logic [31:0] dly_us;
      logic [1:0] band;
      logic [31:0] ref_val;
      logic [1:0] stable;
      logic [31:0] held;
      logic held_valid;
      logic beep;
      logic done_n;
      logic start;
      logic waiting;
      logic busy;
   } mts_state_t;

   function automatic logic [31:0] auto_delay_us(input logic [2:0] fn, input logic [2:0] rng,
         input logic integration_line_cycles_ge1, input logic [1:0] flt, input logic fp_auto);
      logic [31:0] d;
      d = integration_line_cycles_ge1 ? D1MS5 : D1MS0;
      case (fn)
         FN_OHM2, FN_OHM4:
         begin
            if (rng > RNG_1M)
               d = D100MS;
            else if (rng == RNG_1M)
               d = integration_line_cycles_ge1 ? D15MS : D10MS;
         end
         FN_ACV, FN_ACI:
         begin
            if (fp_auto)
               d = (flt == FLT_SLOW) ? D1S5 : (flt == FLT_MED) ? D200MS : D100MS;
            else
               d = (flt == FLT_SLOW) ? D7S0 : (flt == FLT_MED) ? D1S0 : D600MS;
         end
         FN_FREQ, FN_PER: d = fp_auto ? 32'h0 : D1S0;
         default: d = integration_line_cycles_ge1 ? D1MS5 : D1MS0;
      endcase
      return d;
   endfunction
endpackage

//--- dv/mts_switch_model.sv
// switching system and analog front end as seen from the sequencer
// assumes the bench sets value_i and calls ext_pulse from the clock domain
`timescale 1ns/1ps
module mts_switch_model #(
   parameter int LAT = 4
) (
   input wire logic clk_i, // system clock
   input wire logic meas_start_i, // start one reading
   input wire logic [31:0] value_i, // value of the next reading
   output logic ext_trig_n_o, // trigger, low true
   output logic meas_done_o, // reading finished pulse
   output logic [31:0] reading_o // reading, valid with done
);
   int wait_q = -1;
   initial
   begin
      ext_trig_n_o = 1'b1;
      meas_done_o = 1'b0;
      reading_o = 32'h0;
   end
   // held low for five edges so the two-flop sync cannot miss it; idles high like a pull-up
   task automatic ext_pulse();
      @(posedge clk_i);
      ext_trig_n_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      ext_trig_n_o <= 1'b1;
   endtask
   // outside the done cycle the data toggles, so a stale value never looks valid
   always @(posedge clk_i)
   begin
      meas_done_o <= 1'b0;
      reading_o <= ~reading_o;
      if (meas_start_i)
         wait_q <= LAT;
      else if (wait_q > 0)
         wait_q <= wait_q - 1;
      else if (wait_q == 0)
      begin
         meas_done_o <= 1'b1;
         reading_o <= value_i;
         wait_q <= -1;
      end
   end
endmodule // mts_switch_model

//--- dv/tb_top.sv
// self-checking bench for the trigger sequencer core
// assumes the switching model answers each start a few cycles later
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module tb_top;
   localparam int US = 1;
   localparam int CFG = 1, CLR = 2, ARM = 3, BUS = 4, SGL = 5;
   localparam int STC = 6, SSC = 7, SDL = 8, SAD = 9, SBD = 10;
   localparam int M_ST = 3, M_DN = 2, M_WT = 1, M_BZ = 0;
   logic clk;
   logic rst = 1'b1;
   logic [10:0] p = '0;
   logic [31:0] v = '0;
   logic [31:0] val = 32'd1000;
   logic [2:0] fn = mts_pkg::FN_DCV;
   logic [2:0] rng = 3'h0;
   logic integration_line_cycles = 1'b1;
   logic remote = 1'b0;
   logic auto_t = 1'b0;
   logic hold = 1'b0;
   logic [1:0] src = 2'h0;
   logic [1:0] flt = 2'h0;
   logic start_o, done_n, wait_o, busy_o, held_valid, beep_o, ext_n, mdone;
   logic [31:0] held, rdg;
   int n_errors = 0;
   int num_checks = 0;
   int n_beep = 0;
   int n_start = 0;
   logic [2:0] tf [5] = '{mts_pkg::FN_DCV, mts_pkg::FN_DCI, mts_pkg::FN_OHM2,
      mts_pkg::FN_OHM4, mts_pkg::FN_OHM2};
   logic [2:0] tr [5] = '{3'h0, 3'h0, 3'h3, 3'h4, 3'h4};
   logic tn [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   int td [5] = '{1500, 1000, 1000, 15000, 10000};
   wire logic [3:0] mon = {start_o, done_n, wait_o, busy_o};

   mts_core #(.US_CYC(US), .SETUP_US(20)) dut (
      .CLK_I(clk), .SRST_I(rst), .IFC_RESET_I(p[0]), .CONFIG_CMD_I(p[CFG]),
      .DEV_CLEAR_I(p[CLR]), .REMOTE_I(remote), .TRIG_SRC_I(src), .AUTO_TRIG_I(auto_t),
      .ARM_I(p[ARM]), .BUS_TRIG_I(p[BUS]), .SINGLE_I(p[SGL]), .EXT_TRIG_N_I(ext_n),
      .SET_TRIG_COUNT_I(p[STC]), .TRIG_COUNT_I(v[15:0]), .UNLIMITED_TRIGGERS_I(1'b0),
      .SET_SAMPLE_COUNT_I(p[SSC]), .SAMPLE_COUNT_I(v[15:0]), .SET_DELAY_I(p[SDL]),
      .DELAY_US_I(v), .SET_AUTO_DELAY_I(p[SAD]), .FUNC_I(fn), .RANGE_I(rng),
      .INTEGRATION_LINE_CYCLES_GE1_I(integration_line_cycles), .AC_FILTER_I(flt), .MEAS_DONE_I(mdone), .READING_I(rdg),
      .HOLD_EN_I(hold), .SET_BAND_I(p[SBD]), .BAND_SEL_I(v[1:0]), .BEEP_EN_I(1'b1),
      .MEAS_START_O(start_o), .MEASUREMENT_DONE_OUT_N_O(done_n), .WAIT_TRIG_O(wait_o),
      .BUSY_O(busy_o), .HELD_VALUE_O(held), .HELD_VALID_O(held_valid), .BEEP_O(beep_o));

   mts_switch_model sw (.clk_i(clk), .meas_start_i(start_o), .value_i(val),
      .ext_trig_n_o(ext_n), .meas_done_o(mdone), .reading_o(rdg));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(negedge clk)
   begin
      if (beep_o === 1'b1)
         n_beep++;
      if (start_o === 1'b1)
         n_start++;
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic pulse(input int b, input logic [31:0] vv);
      @(posedge clk);
      p[b] <= 1'b1;
      v <= vv;
      @(posedge clk);
      p[b] <= 1'b0;
   endtask

   task automatic wait_lvl(input int i, input logic lv, input int lim, output int n);
      n = 0;
      while (mon[i] !== lv && n < lim)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   // the latency window is loose by a few cycles: the trigger path has sync stages
   task automatic readings(input int d, input int ns);
      int n;
      repeat (ns)
      begin
         wait_lvl(M_ST, 1'b1, 40000, n);
         `CHK(n >= d * US - 5 && n <= d * US + 8, 1'b1)
         wait_lvl(M_DN, 1'b0, 50, n);
         `CHK(done_n, 1'b0)
         @(negedge clk);
         `CHK(done_n, 1'b1)
      end
   endtask

   initial
   begin
      int n;
      int k;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK(done_n, 1'b1)
      `CHK(busy_o, 1'b0)
      repeat (3) @(negedge clk);
      `CHK(wait_o, 1'b1)
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk);
         fn <= tf[i];
         rng <= tr[i];
         integration_line_cycles <= tn[i];
         pulse(SGL, 0);
         readings(td[i], 1);
      end
      @(posedge clk);
      fn <= mts_pkg::FN_ACV;
      hold <= 1'b1;
      pulse(SDL, 7);
      pulse(SSC, 3);
      pulse(SGL, 0);
      readings(7, 3);
      repeat (3) @(negedge clk);
      `CHK(held, 32'd1000)
      `CHK(held_valid, 1'b1)
      `CHK(n_beep, 1)
      // 10 percent band latches 1000, 1045, 1090; the 0.01 percent band must not
      pulse(SSC, 1);
      for (int j = 0; j < 2; j++)
      begin
         pulse(SBD, j ? 32'h0 : 32'h3);
         for (int i = 0; i < 3; i++)
         begin
            @(posedge clk);
            val <= 32'd1000 + 32'(i * 45);
            pulse(SGL, 0);
            readings(7, 1);
         end
         repeat (3) @(negedge clk);
         `CHK(held, 32'd1090)
      end
      `CHK(n_beep, 2)
      @(posedge clk);
      hold <= 1'b0;
      pulse(SSC, 1);
      pulse(SAD, 0);
      @(posedge clk);
      fn <= mts_pkg::FN_FREQ;
      auto_t <= 1'b1;
      readings(0, 2);
      // front-panel auto ac, fast filter: the delay is loaded, then cut short by a clear
      @(posedge clk);
      fn <= mts_pkg::FN_ACV;
      flt <= 2'h2;
      repeat (20) @(negedge clk);
      `CHK(dut.s_q.cnt > 32'd99900 && dut.s_q.cnt <= 32'd100000, 1'b1)
      @(posedge clk);
      auto_t <= 1'b0;
      pulse(CLR, 0);
      wait_lvl(M_BZ, 1'b0, 200, n);
      @(posedge clk);
      remote <= 1'b1;
      src <= mts_pkg::SRC_IMM;
      flt <= 2'h0;
      pulse(STC, 2);
      pulse(ARM, 0);
      wait_lvl(M_BZ, 1'b1, 100, n);
      `CHK(busy_o, 1'b1)
      `CHK(dut.s_q.cnt > 32'd6990000 && dut.s_q.cnt <= 32'd7000000, 1'b1)
      k = n_start;
      repeat (5000) @(negedge clk);
      `CHK(n_start, k)
      pulse(CLR, 0);
      @(negedge clk);
      `CHK(busy_o, 1'b0)
      `CHK(wait_o, 1'b0)
      @(posedge clk);
      src <= mts_pkg::SRC_EXT;
      fn <= mts_pkg::FN_DCV;
      integration_line_cycles <= 1'b1;
      pulse(SDL, 50);
      pulse(ARM, 0);
      sw.ext_pulse();
      wait_lvl(M_WT, 1'b1, 100, n);
      repeat (4) @(negedge clk);
      `CHK(busy_o, 1'b0)
      sw.ext_pulse();
      fork
         begin
            // lands while the first reading is in progress, so it must be stored
            repeat (49) @(posedge clk);
            sw.ext_pulse();
         end
      join_none
      readings(50, 2);
      repeat (4) @(negedge clk);
      `CHK(wait_o, 1'b0)
      @(posedge clk);
      src <= mts_pkg::SRC_BUS;
      pulse(CFG, 0);
      pulse(ARM, 0);
      wait_lvl(M_WT, 1'b1, 100, n);
      sw.ext_pulse();
      repeat (4) @(negedge clk);
      `CHK(busy_o, 1'b0)
      pulse(BUS, 0);
      readings(1500, 1);
      repeat (4) @(negedge clk);
      `CHK(wait_o, 1'b0)
      pulse(0, 0);
      @(negedge clk);
      `CHK(done_n, 1'b1)
      end_of_test();
   end

   // the whole sequence needs some 40000 cycles
   initial
   begin
      repeat (100000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
endmodule // tb_top
